// ---- rtl/kbh_fifo.v ----
`timescale 1ns/1ps
`include "kbh_map.vh"
module kbh_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // storage array, read asynchronously at the head
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  // occupancy; one extra bit so full and empty differ
  reg [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  // data write, no reset needed on storage
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // pointers wrap at DEPTH, which need not be a power of two
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // kbh_fifo

// ---- rtl/kbh_map.vh ----
`ifndef KBH_MAP_VH
`define KBH_MAP_VH
// host i/o addresses (data port and command/status port)
`define KBH_IO_DATA 8'h60
`define KBH_IO_CMD 8'h64
// status register bit positions
`define KBH_ST_OBF 0
`define KBH_ST_IBF 1
`define KBH_ST_SYS 2
`define KBH_ST_CD 3
`define KBH_ST_INH 4
`define KBH_ST_AUX 5
`define KBH_ST_TMO 6
`define KBH_ST_PAR 7
// configuration byte bit positions
`define KBH_CF_KIRQ 0
`define KBH_CF_MIRQ 1
`define KBH_CF_SYS 2
`define KBH_CF_NOLOCK 3
`define KBH_CF_KDIS 4
`define KBH_CF_MDIS 5
`define KBH_CF_XLAT 6
`define KBH_CF_RSVD 7
`define KBH_CFG_RESET 8'h00
// command codes
`define KBH_CMD_RDCFG 8'h20
`define KBH_CMD_WRCFG 8'h60
`define KBH_CMD_GRP_RD 2'b00
`define KBH_CMD_GRP_WR 2'b01
// internal ram
`define KBH_RAM_WORDS 32
`define KBH_RAM_AW 5
// scan code break prefix
`define KBH_BRK_PREFIX 8'hf0
// link frame: start, 8 data, parity, stop
`define KBH_FRAME_LAST 4'd10
`endif

// ---- rtl/kbh_rx.v ----
`timescale 1ns/1ps
`include "kbh_map.vh"
module kbh_rx (
  input wire clk,
  input wire sys_rst,
  input wire en,
  input wire ps_clk_i,
  input wire ps_data_i,
  input wire ready,
  output reg valid,
  output reg [7:0] byte_o,
  output reg perr
);
  // three-stage synchronisers for the pins
  reg cs1_r, cs2_r, cs3_r;
  reg ds1_r, ds2_r, ds3_r;
  // filtered clock level, moves only when stages two and three agree
  reg clk_lvl_r;
  reg [8:0] sh_r;
  reg [3:0] cnt_r;
  wire agree = (cs2_r == cs3_r);
  wire fall = clk_lvl_r & agree & ~cs3_r;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs1_r <= 1'b1;
      cs2_r <= 1'b1;
      cs3_r <= 1'b1;
      ds1_r <= 1'b1;
      ds2_r <= 1'b1;
      ds3_r <= 1'b1;
      clk_lvl_r <= 1'b1;
    end else begin
      cs1_r <= ps_clk_i;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      ds1_r <= ps_data_i;
      ds2_r <= ds1_r;
      ds3_r <= ds2_r;
      if (agree) begin
        clk_lvl_r <= cs3_r;
      end
    end
  end
  // frame shifter; a held byte or disable stops reception
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_r <= 9'h000;
      cnt_r <= 4'd0;
      valid <= 1'b0;
      byte_o <= 8'h00;
      perr <= 1'b0;
    end else begin
      if (valid & ready) begin
        valid <= 1'b0;
      end
      if (~en | valid) begin
        // partial frame is dropped while the link is inhibited
        cnt_r <= 4'd0;
      end else if (fall) begin
        if (cnt_r == 4'd0) begin
          // wait for a low start bit
          if (~ds3_r) begin
            cnt_r <= 4'd1;
          end
        end else if (cnt_r == `KBH_FRAME_LAST) begin
          cnt_r <= 4'd0;
          valid <= 1'b1;
          byte_o <= sh_r[7:0];
          // odd parity over data and parity bit
          perr <= ~(^sh_r);
        end else begin
          sh_r <= {ds3_r, sh_r[8:1]};
          cnt_r <= cnt_r + 4'd1;
        end
      end
    end
  end
endmodule // kbh_rx

// ---- rtl/kbh_top.v ----
`timescale 1ns/1ps
`include "kbh_map.vh"
// How it works
// R1: obf flag set on load, until read
// R2: write-only input buffer at 60/64
// R3: write address marks byte data or command
// R4: data goes to keyboard unless parameter awaited
// R5: host writes only while ibf reads 0
// R6: read-only output buffer read at 60
// R7: output buffer carries scan codes and replies
// R8: host reads only while obf reads 1
// R9: commands 00-1F, 21-3F return ram byte
// R10: command 20 returns configuration byte
// R11: commands 40-5F write next data to ram
// R12: command 60 writes next data to configuration
// R13: config bit 0 enables keyboard data interrupt
// R14: config bit 1 mouse interrupt, reserved otherwise
// R15: config bit 2 shows as status system flag
// R16: config bit 3 ignores lock switch
// R17: config bit 5 holds mouse clock low
// R18: config bit 6 translates scan codes
// R19: config bit 4 holds keyboard clock low
// R20: commands 61-7F write next data to ram
// R21: status register readable at 64 anytime
// R22: status bit 3 shows last write port
// R23: ibf set on write, cleared when consumed
// R24: read at 60 clears obf; config resets zero
module kbh_top #(
  parameter PS2_MODE = 1,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output reg io_rvalid,
  output reg kbd_tx_stb,
  output reg [7:0] kbd_tx_byte,
  input wire kbd_clk_i,
  input wire kbd_data_i,
  output wire kbd_clk_o,
  output reg kbd_clk_oe,
  input wire mouse_clk_i,
  input wire mouse_data_i,
  output wire mouse_clk_o,
  output reg mouse_clk_oe,
  input wire keyboard_lock_switch_input,
  output wire kbd_irq,
  output wire mouse_irq
);
  // parameter wait states, one-hot
  localparam ST_IDLE = 3'b001;
  localparam ST_WRAM = 3'b010;
  localparam ST_WCFG = 3'b100;
  // address match, used by both read and write decode
  function hit;
    input [7:0] addr;
    input [7:0] want;
    begin
      hit = (addr == want);
    end
  endfunction
  // partial set-2 to legacy code table; unknown codes keep their low seven bits
  function [6:0] xlate;
    input [7:0] code;
    begin
      case (code)
        8'h76: xlate = 7'h01;
        8'h16: xlate = 7'h02;
        8'h1e: xlate = 7'h03;
        8'h26: xlate = 7'h04;
        8'h25: xlate = 7'h05;
        8'h2e: xlate = 7'h06;
        8'h36: xlate = 7'h07;
        8'h3d: xlate = 7'h08;
        8'h3e: xlate = 7'h09;
        8'h46: xlate = 7'h0a;
        8'h45: xlate = 7'h0b;
        8'h66: xlate = 7'h0e;
        8'h0d: xlate = 7'h0f;
        8'h15: xlate = 7'h10;
        8'h1d: xlate = 7'h11;
        8'h24: xlate = 7'h12;
        8'h2d: xlate = 7'h13;
        8'h5a: xlate = 7'h1c;
        8'h14: xlate = 7'h1d;
        8'h1c: xlate = 7'h1e;
        8'h1b: xlate = 7'h1f;
        8'h12: xlate = 7'h2a;
        8'h11: xlate = 7'h38;
        8'h29: xlate = 7'h39;
        default: xlate = code[6:0];
      endcase
    end
  endfunction
  reg [7:0] wbuf_r; // input buffer byte
  reg ibf_r; // input buffer full
  reg cd_r; // 1: last write was a command
  reg [7:0] obuf_r; // output buffer byte
  reg obf_r; // output buffer full
  reg aux_r; // output byte came from mouse
  reg perr_r; // parity error of output byte
  reg [7:0] cfg_r; // configuration byte
  reg [7:0] ram_r [0:`KBH_RAM_WORDS-1]; // internal ram
  reg [2:0] st_r; // parameter wait state
  reg [`KBH_RAM_AW-1:0] pidx_r; // ram index awaiting data
  reg rep_r; // command reply waiting for the output buffer
  reg [7:0] rep_byte_r; // the reply itself
  reg brk_r; // break prefix seen while translating
  reg lk1_r, lk2_r, lk3_r; // lock switch synchroniser
  reg lock_r; // filtered lock level
  wire wr_data = io_wr & hit(io_addr, `KBH_IO_DATA);
  wire wr_cmd = io_wr & hit(io_addr, `KBH_IO_CMD);
  wire rd_data = io_rd & hit(io_addr, `KBH_IO_DATA);
  wire rd_stat = io_rd & hit(io_addr, `KBH_IO_CMD);
  // controller takes the byte only when the reply slot is free
  wire consume = ibf_r & ~rep_r;
  wire [1:0] grp = wbuf_r[7:6];
  // keyboard inhibited by the lock switch unless told to ignore it
  // R16: lock switch ignore
  wire lock_inh = lock_r & ~cfg_r[`KBH_CF_NOLOCK];
  wire kbd_en = ~cfg_r[`KBH_CF_KDIS] & ~lock_inh;
  wire ms_en = (PS2_MODE != 0) & ~cfg_r[`KBH_CF_MDIS];
  // receivers feed the fifo; keyboard wins a tie
  wire kv, mv;
  wire [7:0] kb, mb;
  wire kp, mp;
  wire f_in_ready;
  wire k_ready = f_in_ready;
  wire m_ready = f_in_ready & ~kv;
  wire [9:0] f_in = kv ? {1'b0, kp, kb} : {1'b1, mp, mb};
  wire f_out_valid;
  wire [9:0] f_out;
  // fifo drains only into an empty output buffer, replies first
  wire f_out_ready = ~obf_r & ~rep_r;
  wire pop = f_out_valid & f_out_ready;
  wire f_kbd = ~f_out[9];
  wire do_xlat = f_kbd & cfg_r[`KBH_CF_XLAT];
  wire swallow = do_xlat & (f_out[7:0] == `KBH_BRK_PREFIX);
  assign kbd_clk_o = 1'b0;
  assign mouse_clk_o = 1'b0;
  // R13: keyboard data interrupt
  assign kbd_irq = obf_r & ~aux_r & cfg_r[`KBH_CF_KIRQ];
  // R14: mouse data interrupt
  assign mouse_irq = obf_r & aux_r & cfg_r[`KBH_CF_MIRQ];
  kbh_rx u_krx (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(kbd_en),
    .ps_clk_i(kbd_clk_i),
    .ps_data_i(kbd_data_i),
    .ready(k_ready),
    .valid(kv),
    .byte_o(kb),
    .perr(kp)
  );
  kbh_rx u_mrx (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(ms_en),
    .ps_clk_i(mouse_clk_i),
    .ps_data_i(mouse_data_i),
    .ready(m_ready),
    .valid(mv),
    .byte_o(mb),
    .perr(mp)
  );
  kbh_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(kv | mv),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );
  // lock switch pin: three flops, change taken when two and three agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk1_r <= 1'b0;
      lk2_r <= 1'b0;
      lk3_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      lk1_r <= keyboard_lock_switch_input;
      lk2_r <= lk1_r;
      lk3_r <= lk2_r;
      if (lk2_r == lk3_r) begin
        lock_r <= lk3_r;
      end
    end
  end
  // link clock hold: disabled, or a received byte cannot be stored
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kbd_clk_oe <= 1'b0;
      mouse_clk_oe <= 1'b0;
    end else begin
      // R19: keyboard clock held low
      kbd_clk_oe <= ~kbd_en | (kv & ~k_ready);
      // R17: mouse clock held low
      mouse_clk_oe <= ~ms_en | (mv & ~m_ready);
    end
  end
  // host reads; data comes out one cycle after the strobe
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= rd_data | rd_stat;
      if (rd_data) begin
        // R6: output buffer read
        io_rdata <= obuf_r;
      end else if (rd_stat) begin
        // R21: status byte; R15 system flag, R22 command/data
        io_rdata <= {perr_r, 1'b0, aux_r, ~lock_inh, cd_r, cfg_r[`KBH_CF_SYS], ibf_r, obf_r};
      end
    end
  end
  // ram has no reset; contents are whatever software wrote
  always @(posedge clk) begin
    // R11: ram write from parameter byte; R20 likewise
    if (consume & ~cd_r & st_r[1]) begin
      ram_r[pidx_r] <= wbuf_r;
    end
  end
  // input buffer and command interpreter
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wbuf_r <= 8'h00;
      ibf_r <= 1'b0;
      cd_r <= 1'b0;
      cfg_r <= `KBH_CFG_RESET;
      st_r <= ST_IDLE;
      pidx_r <= {`KBH_RAM_AW{1'b0}};
      rep_r <= 1'b0;
      rep_byte_r <= 8'h00;
      kbd_tx_stb <= 1'b0;
      kbd_tx_byte <= 8'h00;
    end else begin
      kbd_tx_stb <= 1'b0;
      if (rep_r & ~obf_r) begin
        rep_r <= 1'b0;
      end
      if (consume & cd_r) begin
        st_r <= ST_IDLE;
        if (wbuf_r == `KBH_CMD_RDCFG) begin
          // R10: configuration byte reply
          rep_r <= 1'b1;
          rep_byte_r <= cfg_r;
        end else if (wbuf_r == `KBH_CMD_WRCFG) begin
          st_r <= ST_WCFG;
        end else if (grp == `KBH_CMD_GRP_RD) begin
          // R9: ram byte reply
          rep_r <= 1'b1;
          rep_byte_r <= ram_r[wbuf_r[`KBH_RAM_AW-1:0]];
        end else if (grp == `KBH_CMD_GRP_WR) begin
          // R11: await ram data; R20 too
          st_r <= ST_WRAM;
          pidx_r <= wbuf_r[`KBH_RAM_AW-1:0];
        end
      end else if (consume) begin
        // R4: parameter wait consumes data
        case (st_r)
          ST_WRAM: begin
            st_r <= ST_IDLE;
          end
          ST_WCFG: begin
            // R12: load configuration; R14 reserved bit
            cfg_r <= {1'b0, wbuf_r[6:2], wbuf_r[1] & (PS2_MODE != 0), wbuf_r[0]};
            st_r <= ST_IDLE;
          end
          default: begin
            // R4: forward to keyboard
            kbd_tx_stb <= 1'b1;
            kbd_tx_byte <= wbuf_r;
            st_r <= ST_IDLE;
          end
        endcase
      end
      if (wr_data | wr_cmd) begin
        // R2: buffer the byte; R3 mark its kind
        wbuf_r <= io_wdata;
        cd_r <= wr_cmd;
        // R23: set wins over consume
        ibf_r <= 1'b1;
      end else if (consume) begin
        // R23: cleared once consumed
        ibf_r <= 1'b0;
      end
    end
  end
  // output buffer loader
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      obuf_r <= 8'h00;
      obf_r <= 1'b0;
      aux_r <= 1'b0;
      perr_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      if (rep_r & ~obf_r) begin
        // R7: reply into output buffer; R1 flag set
        obuf_r <= rep_byte_r;
        obf_r <= 1'b1;
        aux_r <= 1'b0;
        perr_r <= 1'b0;
      end else if (pop & swallow) begin
        // R18: two-byte break collapses
        brk_r <= 1'b1;
      end else if (pop) begin
        // R7: scan code into output buffer; R1 flag set
        obf_r <= 1'b1;
        aux_r <= ~f_kbd;
        perr_r <= f_out[8];
        if (do_xlat) begin
          // R18: legacy code with break bit
          obuf_r <= {brk_r, xlate(f_out[7:0])};
          brk_r <= 1'b0;
        end else begin
          obuf_r <= f_out[7:0];
        end
      end else if (rd_data) begin
        // R24: host read empties the buffer
        obf_r <= 1'b0;
      end
    end
  end
endmodule // kbh_top

// ---- verification/kbh_link_dev.sv ----
`timescale 1ns/1ps
module kbh_link_dev (
  output logic lclk,
  output logic ldat
);
  // idle lines rest at the pull-up level, clock stands still
  initial begin
    lclk = 1'b1;
    ldat = 1'b1;
  end
  // one frame: start, data lsb first, odd parity, stop
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    int i;
    f = {1'b1, ~^b, b, 1'b0};
    for (i = 0; i < 11; i++) begin
      ldat = f[i];
      #20;
      lclk = 1'b0;
      #40;
      lclk = 1'b1;
      #20;
    end
    // released data returns to the pull-up
    ldat = 1'b1;
  endtask
endmodule // kbh_link_dev

// ---- verification/kbh_top_sva.sv ----
`timescale 1ns/1ps
module kbh_top_sva (
  input wire clk,
  input wire sys_rst,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_addr,
  input wire [7:0] io_rdata,
  input wire io_rvalid,
  input wire kbd_tx_stb,
  input wire kbd_clk_o,
  input wire kbd_clk_oe,
  input wire mouse_clk_o,
  input wire mouse_clk_oe,
  input wire kbd_irq,
  input wire mouse_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // host write aimed at the data port
  wire wr_data = io_wr && io_addr == 8'h60;
  // any read that the block decodes
  wire rd_any = io_rd && (io_addr == 8'h60 || io_addr == 8'h64);
  property p_rd_data; io_rd && io_addr == 8'h60 |=> io_rvalid; endproperty
  a_rd_data: assert property (p_rd_data) else $error("data read not answered");
  property p_rd_stat; io_rd && io_addr == 8'h64 |=> io_rvalid; endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status read not answered");
  property p_no_rvalid; !rd_any |=> !io_rvalid; endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("answer without a read");
  property p_rdata_hold; !io_rvalid |-> $stable(io_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_tx_cause; kbd_tx_stb |-> $past(wr_data, 1) || $past(wr_data, 2) || $past(wr_data, 3); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("forward strobe without data write");
  property p_irq_excl; !(kbd_irq && mouse_irq); endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both interrupts high");
  property p_kclk; kbd_clk_oe |-> kbd_clk_o == 1'b0; endproperty
  a_kclk: assert property (p_kclk) else $error("keyboard clock driven high");
  property p_mclk; mouse_clk_oe |-> mouse_clk_o == 1'b0; endproperty
  a_mclk: assert property (p_mclk) else $error("mouse clock driven high");
  c_rd: cover property (io_rd && io_addr == 8'h60 ##1 io_rvalid);
  c_kirq: cover property ($rose(kbd_irq));
  c_mirq: cover property ($rose(mouse_irq));
  c_tx: cover property (kbd_tx_stb);
endmodule // kbh_top_sva
bind kbh_top kbh_top_sva i_kbh_top_sva (.clk(clk), .sys_rst(sys_rst), .io_wr(io_wr), .io_rd(io_rd),
  .io_addr(io_addr), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .kbd_tx_stb(kbd_tx_stb),
  .kbd_clk_o(kbd_clk_o), .kbd_clk_oe(kbd_clk_oe), .mouse_clk_o(mouse_clk_o),
  .mouse_clk_oe(mouse_clk_oe), .kbd_irq(kbd_irq), .mouse_irq(mouse_irq));

// ---- verification/test_keyboard_controller_host_interface.sv ----
`timescale 1ns/1ps
module test_keyboard_controller_host_interface;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [7:0] io_wdata = 8'h00;
  logic lock = 1'b0;
  wire [7:0] io_rdata;
  wire [7:0] kbd_tx_byte;
  wire io_rvalid, kbd_tx_stb, kbd_clk_o, kbd_clk_oe, mouse_clk_o, mouse_clk_oe, kbd_irq, mouse_irq;
  wire kclk, kdat, mclk, mdat;
  // open-drain clock: the block wins when it pulls low
  wire kbd_clk_i = kbd_clk_oe ? kbd_clk_o : kclk;
  wire mouse_clk_i = mouse_clk_oe ? mouse_clk_o : mclk;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int tx_count = 0;
  int i;
  // ram write cmd, read cmd, data
  logic [23:0] ram_tab [4] = '{24'h45_05a5, 24'h7e_3e3c, 24'h40_005a, 24'h5f_3fc3};
  always #2.5 clk = ~clk;
  kbh_top i_kbh_top (.clk(clk), .sys_rst(sys_rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .kbd_tx_stb(kbd_tx_stb),
    .kbd_tx_byte(kbd_tx_byte), .kbd_clk_i(kbd_clk_i), .kbd_data_i(kdat), .kbd_clk_o(kbd_clk_o),
    .kbd_clk_oe(kbd_clk_oe), .mouse_clk_i(mouse_clk_i), .mouse_data_i(mdat), .mouse_clk_o(mouse_clk_o),
    .mouse_clk_oe(mouse_clk_oe), .keyboard_lock_switch_input(lock), .kbd_irq(kbd_irq), .mouse_irq(mouse_irq));
  kbh_link_dev i_kbh_link_dev (.lclk(kclk), .ldat(kdat));
  kbh_link_dev i_kbh_link_dev_m (.lclk(mclk), .ldat(mdat));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // write then idle four cycles, enough for the byte to be consumed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(negedge clk);
    io_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // answer lands on the taking edge and is checked at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] want, input logic [7:0] m = 8'hff);
    @(negedge clk);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge clk);
    io_rd = 1'b0;
    chk({7'h00, io_rvalid}, 8'h01);
    chk(io_rdata & m, want & m);
  endtask
  task automatic set_cfg(input logic [7:0] d);
    wr(8'h64, 8'h60);
    wr(8'h60, d);
  endtask
  task automatic wait_irq(input logic m);
    int n;
    for (n = 0; n < 100 && (m ? mouse_irq : kbd_irq) !== 1'b1; n++) @(negedge clk);
  endtask
  // cycle ceiling against a hang, forward strobe count
  always @(posedge clk) begin
    cycles++;
    if (kbd_tx_stb === 1'b1) tx_count++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'h64, 8'h10);
    wr(8'h64, 8'h20);
    rd(8'h64, 8'h19);
    rd(8'h60, 8'h00);
    rd(8'h64, 8'h18);
    $display("test reset_and_read_config done");
    // reserved bit 7 never stored
    set_cfg(8'hff);
    rd(8'h64, 8'h14);
    chk({6'h00, kbd_clk_oe, mouse_clk_oe}, 8'h03);
    wr(8'h64, 8'h20);
    rd(8'h60, 8'h7f);
    lock = 1'b1;
    // let the lock level clear its synchroniser before looking
    repeat (6) @(negedge clk);
    rd(8'h64, 8'h1c);
    set_cfg(8'h00);
    rd(8'h64, 8'h00);
    // locked keyboard is inhibited, so its clock is held low
    chk({6'h00, kbd_clk_oe, mouse_clk_oe}, 8'h02);
    lock = 1'b0;
    $display("test config_write done");
    for (i = 0; i < 4; i++) begin
      wr(8'h64, ram_tab[i][23:16]);
      wr(8'h60, ram_tab[i][7:0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h64, ram_tab[i][15:8]);
      rd(8'h60, ram_tab[i][7:0]);
    end
    chk(tx_count[7:0], 8'h00);
    $display("test internal_ram done");
    wr(8'h60, 8'hed);
    chk(tx_count[7:0], 8'h01);
    chk(kbd_tx_byte, 8'hed);
    // undecoded port: no answer, no effect
    wr(8'h61, 8'h20);
    @(negedge clk);
    io_rd = 1'b1;
    io_addr = 8'h62;
    @(negedge clk);
    io_rd = 1'b0;
    chk({7'h00, io_rvalid}, 8'h00);
    rd(8'h64, 8'h10);
    $display("test forward_and_decode done");
    set_cfg(8'h01);
    i_kbh_link_dev.send(8'h1c);
    wait_irq(1'b0);
    chk({6'h00, kbd_irq, mouse_irq}, 8'h02);
    // data port read only once obf shows 1
    rd(8'h64, 8'h11);
    rd(8'h60, 8'h1c);
    chk({7'h00, kbd_irq}, 8'h00);
    set_cfg(8'h02);
    i_kbh_link_dev_m.send(8'h08);
    wait_irq(1'b1);
    rd(8'h64, 8'h31);
    rd(8'h60, 8'h08);
    chk({6'h00, kbd_irq, mouse_irq}, 8'h00);
    $display("test link_bytes done");
    // break prefix alone must load nothing
    set_cfg(8'h41);
    i_kbh_link_dev.send(8'hf0);
    repeat (30) @(negedge clk);
    chk({7'h00, kbd_irq}, 8'h00);
    i_kbh_link_dev.send(8'h1c);
    wait_irq(1'b0);
    rd(8'h64, 8'h11);
    rd(8'h60, 8'h80, 8'h80);
    $display("test translation done");
    summarize();
  end
endmodule // test_keyboard_controller_host_interface
